/* File: logic/bidir_port_pkg.sv */
//==============================================================================
package bidir_port_pkg;

   //==========================================================================
   // register map, word indices on the register port
   localparam logic [2:0] third_pins_addr   = 3'h0;
   localparam logic [2:0] third_latch_addr  = 3'h1;
   localparam logic [2:0] third_dir_addr    = 3'h2;
   localparam logic [2:0] fourth_pins_addr  = 3'h3;
   localparam logic [2:0] fourth_latch_addr = 3'h4;
   localparam logic [2:0] fourth_dir_addr   = 3'h5;
   localparam logic [2:0] fifth_dir_addr    = 3'h6;

   //==========================================================================
   // reset values
   localparam logic [7:0] dir_reset       = 8'hff;
   localparam logic [7:0] latch_reset     = 8'h00;
   localparam logic [7:0] fifth_dir_reset = 8'h0f;

   //==========================================================================
   // field and pin positions
   localparam int slave_enable_bit = 4;
   localparam int capture_compare_unit_two_pin         = 1;
   localparam int clock_pin        = 3;
   localparam int data_pin         = 4;
   localparam int sdo_pin          = 5;
   localparam int tx_pin           = 6;
   localparam int rx_pin           = 7;
   localparam int pwm_b_pin        = 5;
   localparam int pwm_c_pin        = 6;
   localparam int pwm_d_pin        = 7;

   //==========================================================================
   // peripheral controls toward the third port and second port bit3
   typedef struct packed {
      logic two_wire_en;      // two-wire mode of sync_serial_module
      logic scl_out;          // module clock level
      logic sda_drive;        // module pulls data pin
      logic sda_out;          // module data level
      logic four_wire_en;     // four-wire mode of sync_serial_module
      logic sck_out;
      logic sdo_out;
      logic usart_en;         // universal_serial_module enabled
      logic usart_sync;       // synchronous mode
      logic tx_out;           // async transmit level or sync data out
      logic ck_master;        // module drives sync clock
      logic ck_out;
      logic dt_transmit;      // module drives sync data
      logic capture_compare_unit_two_out_en;      // capture_compare_unit_two compare or PWM
      logic capture_compare_unit_two_out;
   } serial_ctl_type;

   // enhanced PWM outputs toward the fourth port
   typedef struct packed {
      logic multi_output;     // dual or quad output mode
      logic [2:0] chan_en;    // channels d, c, b
      logic [2:0] chan_out;
   } pwm_ctl_type;

   // pin levels delivered to the peripherals
   typedef struct packed {
      logic scl_in;
      logic sda_in;
      logic sck_in;
      logic sdi_in;
      logic rx_in;
      logic ck_in;
      logic dt_in;
      logic capture_compare_unit_two_in;
   } periph_in_type;

endpackage

/* File: logic/bidir_port_with_overrides.sv */
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module bidir_port_with_overrides #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic                           i_mclk,
   input  wire logic                           i_rst,
   // register port
   input  wire logic [2:0]                     i_addr,
   input  wire logic [WIDTH-1:0]               i_wdata,
   input  wire logic                           i_wr,
   input  wire logic                           i_rd,
   output logic      [WIDTH-1:0]               o_rdata,
   // configuration and peripheral controls
   input  wire logic                           i_capture2_pin_select,
   input  wire bidir_port_pkg::serial_ctl_type i_serial,
   input  wire bidir_port_pkg::pwm_ctl_type    i_pwm,
   input  wire logic                           i_slave_drive,
   // third port pins
   input  wire logic [WIDTH-1:0]               i_third_pin,
   output logic      [WIDTH-1:0]               o_third_out,
   output logic      [WIDTH-1:0]               o_third_oe,
   output logic                                o_bus_buffer,
   // fourth port pins
   input  wire logic [WIDTH-1:0]               i_fourth_pin,
   output logic      [WIDTH-1:0]               o_fourth_out,
   output logic      [WIDTH-1:0]               o_fourth_oe,
   output logic                                o_fourth_ttl,
   // second port bit3 alternate for capture unit two
   input  wire logic                           i_second_port_bit3_pin,
   output logic                                o_second_bit3_out,
   output logic                                o_second_bit3_oe,
   // peripheral side
   output bidir_port_pkg::periph_in_type       o_periph,
   output logic                                o_slave_active
);

   //==========================================================================
   // register state
   logic [WIDTH-1:0] third_latch;
   logic [WIDTH-1:0] third_dir;
   logic [WIDTH-1:0] third_level;
   logic [WIDTH-1:0] fourth_latch;
   logic [WIDTH-1:0] fourth_dir;
   logic [WIDTH-1:0] fourth_level;
   logic [WIDTH-1:0] fifth_dir;
   logic [WIDTH-1:0] next_third_latch;
   logic [WIDTH-1:0] next_third_dir;
   logic [WIDTH-1:0] next_fourth_latch;
   logic [WIDTH-1:0] next_fourth_dir;
   logic [WIDTH-1:0] next_fifth_dir;
   logic [WIDTH-1:0] next_rdata;

   // write decode and read mux
   always_comb begin
      next_third_latch  = third_latch;
      next_third_dir    = third_dir;
      next_fourth_latch = fourth_latch;
      next_fourth_dir   = fourth_dir;
      next_fifth_dir    = fifth_dir;
      next_rdata        = '0;
      if (i_wr) begin
         case (i_addr)
            bidir_port_pkg::third_pins_addr,
            bidir_port_pkg::third_latch_addr: begin
               next_third_latch = i_wdata;
            end
            bidir_port_pkg::third_dir_addr: begin
               next_third_dir = i_wdata;
            end
            bidir_port_pkg::fourth_pins_addr,
            bidir_port_pkg::fourth_latch_addr: begin
               next_fourth_latch = i_wdata;
            end
            bidir_port_pkg::fourth_dir_addr: begin
               next_fourth_dir = i_wdata;
            end
            bidir_port_pkg::fifth_dir_addr: begin
               next_fifth_dir = i_wdata;
            end
            default: begin
               next_fifth_dir = fifth_dir;
            end
         endcase
      end
      if (i_rd) begin
         case (i_addr)
            bidir_port_pkg::third_pins_addr:   next_rdata = third_level;
            bidir_port_pkg::third_latch_addr:  next_rdata = third_latch;
            bidir_port_pkg::third_dir_addr:    next_rdata = third_dir;
            bidir_port_pkg::fourth_pins_addr:  next_rdata = fourth_level;
            bidir_port_pkg::fourth_latch_addr: next_rdata = fourth_latch;
            bidir_port_pkg::fourth_dir_addr:   next_rdata = fourth_dir;
            bidir_port_pkg::fifth_dir_addr:    next_rdata = fifth_dir;
            default:                           next_rdata = '0;
         endcase
      end
   end

   // register update; all pins come up as inputs
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         third_latch  <= bidir_port_pkg::latch_reset;
         third_dir    <= bidir_port_pkg::dir_reset;
         third_level  <= '0;
         fourth_latch <= bidir_port_pkg::latch_reset;
         fourth_dir   <= bidir_port_pkg::dir_reset;
         fourth_level <= '0;
         fifth_dir    <= bidir_port_pkg::fifth_dir_reset;
         o_rdata      <= '0;
      end else begin
         third_latch  <= next_third_latch;
         third_dir    <= next_third_dir;
         third_level  <= i_third_pin;
         fourth_latch <= next_fourth_latch;
         fourth_dir   <= next_fourth_dir;
         fourth_level <= i_fourth_pin;
         fifth_dir    <= next_fifth_dir;
         o_rdata      <= next_rdata;
      end
   end

   //==========================================================================
   // third port pin multiplexing
   logic [WIDTH-1:0] next_third_out;
   logic [WIDTH-1:0] next_third_oe;
   logic             next_bus_buffer;
   logic             next_second_out;
   logic             next_second_oe;
   logic             capture_compare_unit_two_on_third;

   always_comb begin
      capture_compare_unit_two_on_third   = i_capture2_pin_select;
      // plain port behaviour first
      next_third_out  = third_latch;
      next_third_oe   = ~third_dir;
      next_bus_buffer = i_serial.two_wire_en;
      next_second_out = 1'b0;
      next_second_oe  = 1'b0;
      // capture unit two output on its selected pin
      if (capture_compare_unit_two_on_third) begin
         if (i_serial.capture_compare_unit_two_out_en && !third_dir[bidir_port_pkg::capture_compare_unit_two_pin]) begin
            next_third_out[bidir_port_pkg::capture_compare_unit_two_pin] = i_serial.capture_compare_unit_two_out;
         end
      end else begin
         next_second_out = i_serial.capture_compare_unit_two_out;
         next_second_oe  = i_serial.capture_compare_unit_two_out_en;
      end
      // clock pin: two-wire or four-wire clock when direction is zero
      if (i_serial.two_wire_en && !third_dir[bidir_port_pkg::clock_pin]) begin
         next_third_out[bidir_port_pkg::clock_pin] = i_serial.scl_out;
      end else if (i_serial.four_wire_en && !third_dir[bidir_port_pkg::clock_pin]) begin
         next_third_out[bidir_port_pkg::clock_pin] = i_serial.sck_out;
      end
      // two-wire data pin: module drive wins whatever the direction
      if (i_serial.two_wire_en) begin
         next_third_oe[bidir_port_pkg::data_pin]  = i_serial.sda_drive;
         next_third_out[bidir_port_pkg::data_pin] = i_serial.sda_out;
      end
      // four-wire data out when direction is zero
      if (i_serial.four_wire_en && !third_dir[bidir_port_pkg::sdo_pin]) begin
         next_third_out[bidir_port_pkg::sdo_pin] = i_serial.sdo_out;
      end
      // universal serial module pins
      if (i_serial.usart_en) begin
         if (!i_serial.usart_sync) begin
            next_third_oe[bidir_port_pkg::tx_pin]  = 1'b1;
            next_third_out[bidir_port_pkg::tx_pin] = i_serial.tx_out;
            next_third_oe[bidir_port_pkg::rx_pin]  = 1'b0;
         end else begin
            next_third_oe[bidir_port_pkg::tx_pin]  = i_serial.ck_master;
            next_third_out[bidir_port_pkg::tx_pin] = i_serial.ck_out;
            next_third_oe[bidir_port_pkg::rx_pin]  = i_serial.dt_transmit;
            next_third_out[bidir_port_pkg::rx_pin] = i_serial.tx_out;
         end
      end
   end

   // peripheral input levels taken straight from the pin inputs, then registered
   bidir_port_pkg::periph_in_type next_periph;

   always_comb begin
      next_periph         = '0;
      next_periph.scl_in  = i_third_pin[bidir_port_pkg::clock_pin];
      next_periph.sck_in  = i_third_pin[bidir_port_pkg::clock_pin];
      next_periph.sda_in  = i_third_pin[bidir_port_pkg::data_pin];
      next_periph.sdi_in  = i_third_pin[bidir_port_pkg::data_pin];
      next_periph.rx_in   = i_third_pin[bidir_port_pkg::rx_pin];
      next_periph.ck_in   = i_third_pin[bidir_port_pkg::tx_pin];
      next_periph.dt_in   = i_third_pin[bidir_port_pkg::rx_pin];
      next_periph.capture_compare_unit_two_in = capture_compare_unit_two_on_third ? i_third_pin[bidir_port_pkg::capture_compare_unit_two_pin]
                                          : i_second_port_bit3_pin;
   end

   //==========================================================================
   // fourth port: slave mode and PWM sharing
   logic             slave_on;
   logic [WIDTH-1:0] next_fourth_out;
   logic [WIDTH-1:0] next_fourth_oe;

   always_comb begin
      // multi-output PWM forces the slave port off
      slave_on = fifth_dir[bidir_port_pkg::slave_enable_bit] && !i_pwm.multi_output;
      next_fourth_out = fourth_latch;
      next_fourth_oe  = ~fourth_dir;
      if (slave_on) begin
         next_fourth_oe = {WIDTH{i_slave_drive}};
      end
      // PWM channels take priority over port and slave data on pins whose direction bit is zero
      for (int k = 0; k < 3; k++) begin
         if (i_pwm.chan_en[k] && !fourth_dir[bidir_port_pkg::pwm_b_pin + k]) begin
            next_fourth_oe[bidir_port_pkg::pwm_b_pin + k]  = 1'b1;
            next_fourth_out[bidir_port_pkg::pwm_b_pin + k] = i_pwm.chan_out[k];
         end
      end
   end

   // output registers
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_third_out       <= '0;
         o_third_oe        <= '0;
         o_bus_buffer      <= 1'b0;
         o_fourth_out      <= '0;
         o_fourth_oe       <= '0;
         o_fourth_ttl      <= 1'b0;
         o_second_bit3_out <= 1'b0;
         o_second_bit3_oe  <= 1'b0;
         o_periph          <= '0;
         o_slave_active    <= 1'b0;
      end else begin
         o_third_out       <= next_third_out;
         o_third_oe        <= next_third_oe;
         o_bus_buffer      <= next_bus_buffer;
         o_fourth_out      <= next_fourth_out;
         o_fourth_oe       <= next_fourth_oe;
         o_fourth_ttl      <= slave_on;
         o_second_bit3_out <= next_second_out;
         o_second_bit3_oe  <= next_second_oe;
         o_periph          <= next_periph;
         o_slave_active    <= slave_on;
      end
   end

   //==========================================================================
   // checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   chk_plain_pin_dir: assert property (
      !$past(i_rst) |-> (o_third_oe[0] == !$past(third_dir[0]))
         && ($past(third_dir[0]) || o_third_out[0] == $past(third_latch[0])))
      else $error("plain pin direction or data wrong");

   chk_latch_readback: assert property (
      (i_wr && i_addr == bidir_port_pkg::third_latch_addr) ##1
      (i_rd && i_addr == bidir_port_pkg::third_latch_addr && !i_wr)
      |=> o_rdata == $past(i_wdata, 2))
      else $error("latch read did not return written value");

   chk_reset_inputs: assert property (
      $fell(i_rst) |-> third_dir == bidir_port_pkg::dir_reset
         && fourth_dir == bidir_port_pkg::dir_reset && o_third_oe == '0)
      else $error("pins not inputs after reset");

   chk_slave_mode: assert property (
      !$past(i_rst) |-> o_fourth_ttl ==
         ($past(fifth_dir[bidir_port_pkg::slave_enable_bit]) && !$past(i_pwm.multi_output)))
      else $error("slave mode or buffer type wrong");

   chk_pwm_priority: assert property (
      i_pwm.chan_en[0] && !fourth_dir[bidir_port_pkg::pwm_b_pin]
      |=> o_fourth_oe[bidir_port_pkg::pwm_b_pin]
         && o_fourth_out[bidir_port_pkg::pwm_b_pin] == $past(i_pwm.chan_out[0]))
      else $error("pwm output b not on pin");

   chk_scl_drive: assert property (
      i_serial.two_wire_en && !third_dir[bidir_port_pkg::clock_pin]
      |=> o_third_oe[bidir_port_pkg::clock_pin]
         && o_third_out[bidir_port_pkg::clock_pin] == $past(i_serial.scl_out))
      else $error("two-wire clock not driven");

   chk_sda_drive: assert property (
      i_serial.two_wire_en |=> o_bus_buffer
         && o_third_oe[bidir_port_pkg::data_pin] == $past(i_serial.sda_drive))
      else $error("two-wire data pin drive wrong");

   chk_sdo_drive: assert property (
      i_serial.four_wire_en && !third_dir[bidir_port_pkg::sdo_pin] && !i_serial.two_wire_en
      |=> o_third_out[bidir_port_pkg::sdo_pin] == $past(i_serial.sdo_out))
      else $error("four-wire data out not driven");

   chk_tx_drive: assert property (
      i_serial.usart_en && !i_serial.usart_sync
      |=> o_third_oe[bidir_port_pkg::tx_pin] && !o_third_oe[bidir_port_pkg::rx_pin]
         && o_third_out[bidir_port_pkg::tx_pin] == $past(i_serial.tx_out))
      else $error("async transmit or receive pin wrong");

   chk_sync_pins: assert property (
      i_serial.usart_en && i_serial.usart_sync
      |=> o_third_oe[bidir_port_pkg::tx_pin] == $past(i_serial.ck_master)
         && o_third_oe[bidir_port_pkg::rx_pin] == $past(i_serial.dt_transmit))
      else $error("sync clock or data direction wrong");

   chk_capture_route: assert property (
      !$past(i_rst) |-> o_periph.capture_compare_unit_two_in == ($past(i_capture2_pin_select)
         ? $past(i_third_pin[bidir_port_pkg::capture_compare_unit_two_pin]) : $past(i_second_port_bit3_pin)))
      else $error("capture unit two input from wrong pin");

   chk_dir_readback: assert property (
      i_rd && i_addr == bidir_port_pkg::third_dir_addr |=> o_rdata == $past(third_dir))
      else $error("direction read not stored contents");

   chk_pin_read: assert property (
      !$past(i_rst) && i_rd && i_addr == bidir_port_pkg::fourth_pins_addr
      |=> o_rdata == $past(i_fourth_pin, 2))
      else $error("pin level read wrong");

   chk_third_pin_read: assert property (
      !$past(i_rst) && i_rd && i_addr == bidir_port_pkg::third_pins_addr
      |=> o_rdata == $past(i_third_pin, 2))
      else $error("third pin level read wrong");

   chk_fourth_plain: assert property (
      !$past(i_rst) && !$past(slave_on) |-> (o_fourth_oe[0] == !$past(fourth_dir[0]))
         && ($past(fourth_dir[0]) || o_fourth_out[0] == $past(fourth_latch[0])))
      else $error("fourth port plain pin wrong");

   chk_slave_drive: assert property (
      slave_on |=> o_fourth_oe[4:0] == {5{$past(i_slave_drive)}}
         && o_fourth_out[4:0] == $past(fourth_latch[4:0]))
      else $error("slave port drive wrong");

   chk_sda_level: assert property (
      i_serial.two_wire_en
      |=> o_third_out[bidir_port_pkg::data_pin] == $past(i_serial.sda_out))
      else $error("two-wire data level wrong");

   chk_rx_route: assert property (
      !$past(i_rst) |-> o_periph.rx_in == $past(i_third_pin[bidir_port_pkg::rx_pin]))
      else $error("receive input from wrong pin");

endmodule

`default_nettype wire

/* File: verification/pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none

//==============================================================================
// far side of one port: the package pins with external drivers
module pin_partner #(
   parameter int WIDTH = 8
) (
   // clock
   input  wire logic             i_mclk,
   // block side of the pins
   input  wire logic [WIDTH-1:0] i_out,
   input  wire logic [WIDTH-1:0] i_oe,
   // external drivers
   input  wire logic [WIDTH-1:0] i_ext,
   input  wire logic [WIDTH-1:0] i_ext_en,
   // resolved pin levels
   output logic      [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] float_pat = '0;

   // a pin nobody drives flips every cycle, so a stale value never passes
   always @(posedge i_mclk) begin
      float_pat <= ~float_pat;
   end

   // external drivers let go while the block drives the pin
   always_comb begin
      for (int k = 0; k < WIDTH; k++) begin
         o_level[k] = i_oe[k] ? i_out[k] : (i_ext_en[k] ? i_ext[k] : float_pat[k]);
      end
   end
endmodule

`default_nettype wire

/* File: verification/tb_bidir_port_with_overrides.sv */
`timescale 1ns/1ps
`default_nettype none

//==============================================================================
// register port sequences against the documented pin behaviour
module tb_bidir_port_with_overrides;
   logic                           i_mclk, i_rst, i_wr, i_rd, cap_sel, slave_drive;
   logic [2:0]                     i_addr;
   logic [7:0]                     i_wdata, o_rdata, third_out, third_oe, fourth_out, fourth_oe;
   logic [7:0]                     third_pin, fourth_pin, third_ext, fourth_ext;
   logic [7:0]                     third_ext_en, fourth_ext_en;
   logic                           bus_buffer, fourth_ttl, sec_out, sec_oe, sec_pin, slave_active;
   bidir_port_pkg::serial_ctl_type serial;
   bidir_port_pkg::pwm_ctl_type    pwm;
   bidir_port_pkg::periph_in_type  periph;
   int                             num_errors = 0;
   int                             num_checks = 0;

   bidir_port_with_overrides bidir_port_with_overrides_inst (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_capture2_pin_select(cap_sel), .i_serial(serial),
      .i_pwm(pwm), .i_slave_drive(slave_drive), .i_third_pin(third_pin),
      .o_third_out(third_out), .o_third_oe(third_oe), .o_bus_buffer(bus_buffer),
      .i_fourth_pin(fourth_pin), .o_fourth_out(fourth_out), .o_fourth_oe(fourth_oe),
      .o_fourth_ttl(fourth_ttl), .i_second_port_bit3_pin(sec_pin),
      .o_second_bit3_out(sec_out), .o_second_bit3_oe(sec_oe), .o_periph(periph),
      .o_slave_active(slave_active));

   // pin models for the three ports
   pin_partner third_pins_inst (.i_mclk(i_mclk), .i_out(third_out),
      .i_oe(third_oe), .i_ext(third_ext), .i_ext_en(third_ext_en), .o_level(third_pin));
   pin_partner fourth_pins_inst (.i_mclk(i_mclk), .i_out(fourth_out),
      .i_oe(fourth_oe), .i_ext(fourth_ext), .i_ext_en(fourth_ext_en), .o_level(fourth_pin));
   pin_partner #(.WIDTH(1)) second_pin_inst (.i_mclk(i_mclk), .i_out(sec_out),
      .i_oe(sec_oe), .i_ext(1'b1), .i_ext_en(1'b1), .o_level(sec_pin));

   //===========================================================================
   // clock, 20 ns period
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end

   // compare tasks: bytes and single bits
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chkb(input string n, input logic e, input logic s);
      chk(n, {7'h00, e}, {7'h00, s});
   endtask

   // bus cycles, entered and left just after a rising edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      chk($sformatf("read data %0d", a), e, o_rdata);
   endtask
   task automatic settle();
      repeat (3) @(posedge i_mclk);
      #1;
   endtask

   // verdict, reached by the tests or by the watchdog
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   //===========================================================================
   // watchdog, far beyond the roughly 120 cycles the tests need
   initial begin
      repeat (5000) @(posedge i_mclk);
      num_errors++;
      close_out();
   end

   // main sequence
   initial begin
      {i_addr, i_wdata, i_wr, i_rd, cap_sel, slave_drive, serial, pwm} = '0;
      i_rst = 1'b1;
      third_ext = 8'h5a;
      fourth_ext = 8'hc3;
      third_ext_en = 8'hff;
      fourth_ext_en = 8'hff;
      repeat (12) @(posedge i_mclk);
      i_rst <= 1'b0;
      #1;
      chk("third oe", 8'h00, third_oe);
      rd(bidir_port_pkg::third_dir_addr, 8'hff);
      rd(bidir_port_pkg::fourth_dir_addr, 8'hff);
      rd(bidir_port_pkg::fifth_dir_addr, 8'h0f);
      wr(3'h7, 8'h00);
      rd(3'h7, 8'h00);
      rd(bidir_port_pkg::third_dir_addr, 8'hff);
      wr(bidir_port_pkg::third_pins_addr, 8'ha5);
      rd(bidir_port_pkg::third_latch_addr, 8'ha5);
      rd(bidir_port_pkg::third_pins_addr, 8'h5a);
      rd(bidir_port_pkg::fourth_pins_addr, 8'hc3);
      wr(bidir_port_pkg::fourth_latch_addr, 8'h5c);
      // one output pin walked across both ports
      for (int k = 0; k < 8; k++) begin
         wr(bidir_port_pkg::third_dir_addr, ~(8'h01 << k));
         wr(bidir_port_pkg::fourth_dir_addr, ~(8'h01 << k));
         settle();
         chk("third oe", 8'h01 << k, third_oe);
         chk("fourth oe", 8'h01 << k, fourth_oe);
         chk("third out", 8'ha5 & (8'h01 << k), third_out & (8'h01 << k));
         chk("fourth out", 8'h5c & (8'h01 << k), fourth_out & (8'h01 << k));
      end
      rd(bidir_port_pkg::third_latch_addr, 8'ha5);
      wr(bidir_port_pkg::third_latch_addr, 8'h00);
      rd(bidir_port_pkg::third_latch_addr, 8'h00);
      // two-wire bus: module clock and data
      serial <= '{two_wire_en: 1'b1, scl_out: 1'b1, sda_drive: 1'b1, default: 1'b0};
      wr(bidir_port_pkg::third_dir_addr, 8'hf7);
      settle();
      chk("two-wire oe", 8'h18, third_oe & 8'h18);
      chk("two-wire out", 8'h08, third_out & 8'h18);
      chkb("bus buffer", 1'b1, bus_buffer);
      rd(bidir_port_pkg::third_dir_addr, 8'hf7);
      serial.sda_drive <= 1'b0;
      wr(bidir_port_pkg::third_dir_addr, 8'hff);
      settle();
      chk("two-wire idle oe", 8'h00, third_oe & 8'h18);
      chkb("scl in", 1'b1, periph.scl_in);
      chkb("sda in", 1'b1, periph.sda_in);
      // four-wire: data out driven, data in read
      serial <= '{four_wire_en: 1'b1, sdo_out: 1'b1, default: 1'b0};
      wr(bidir_port_pkg::third_dir_addr, 8'hdf);
      settle();
      chk("data out pin", 8'h20, third_out & third_oe & 8'h30);
      chkb("data in", 1'b1, periph.sdi_in);
      chkb("sck in", 1'b1, periph.sck_in);
      // asynchronous serial, direction bits ignored
      serial <= '{usart_en: 1'b1, tx_out: 1'b1, default: 1'b0};
      third_ext <= 8'ha5;
      wr(bidir_port_pkg::third_dir_addr, 8'h3f);
      settle();
      chk("async oe", 8'h40, third_oe & 8'hc0);
      chkb("tx out", 1'b1, third_out[6]);
      chkb("rx in", 1'b1, periph.rx_in);
      // synchronous serial, driving then receiving
      serial <= '{usart_en: 1'b1, usart_sync: 1'b1, ck_master: 1'b1, dt_transmit: 1'b1,
                  tx_out: 1'b1, default: 1'b0};
      third_ext <= 8'hc0;
      wr(bidir_port_pkg::third_dir_addr, 8'hff);
      settle();
      chk("sync drive", 8'hc0, third_oe & 8'hc0);
      chk("sync out", 8'h80, third_out & 8'hc0);
      serial.ck_master <= 1'b0;
      serial.dt_transmit <= 1'b0;
      settle();
      chk("sync idle oe", 8'h00, third_oe & 8'hc0);
      chk("sync inputs", 8'h03, {6'h00, periph.ck_in, periph.dt_in});
      // capture unit two on either pin
      serial <= '{capture_compare_unit_two_out_en: 1'b1, capture_compare_unit_two_out: 1'b1, default: 1'b0};
      cap_sel <= 1'b1;
      wr(bidir_port_pkg::third_dir_addr, 8'hfd);
      settle();
      chk("capture main", 8'h02, third_oe & third_out & 8'h02);
      chkb("capture alt oe", 1'b0, sec_oe);
      cap_sel <= 1'b0;
      settle();
      chk("capture alt", 8'h03, {6'h00, sec_oe, sec_out});
      chkb("port bit1 out", 1'b0, third_out[1]);
      serial.capture_compare_unit_two_out_en <= 1'b0;
      settle();
      chkb("capture in alt", 1'b1, periph.capture_compare_unit_two_in);
      // fourth port: slave mode, dual output, PWM channels
      wr(bidir_port_pkg::fourth_dir_addr, 8'hff);
      wr(bidir_port_pkg::fourth_latch_addr, 8'h96);
      wr(bidir_port_pkg::fifth_dir_addr, 8'h1f);
      slave_drive <= 1'b1;
      settle();
      chk("slave flags", 8'h03, {6'h00, fourth_ttl, slave_active});
      chk("slave oe", 8'hff, fourth_oe);
      chk("slave out", 8'h96, fourth_out);
      pwm <= '{multi_output: 1'b1, chan_en: 3'h0, chan_out: 3'h0};
      settle();
      chk("slave off", 8'h00, {6'h00, fourth_ttl, slave_active});
      chk("slave off oe", 8'h00, fourth_oe);
      pwm <= '{multi_output: 1'b1, chan_en: 3'h7, chan_out: 3'h5};
      wr(bidir_port_pkg::fourth_dir_addr, 8'h1f);
      settle();
      chk("pwm oe", 8'he0, fourth_oe);
      chk("pwm out", 8'ha0, fourth_out & 8'he0);
      pwm.multi_output <= 1'b0;
      settle();
      chk("pwm over slave", 8'hb6, fourth_out);
      rd(bidir_port_pkg::fourth_dir_addr, 8'h1f);
      rd(bidir_port_pkg::fifth_dir_addr, 8'h1f);
      close_out();
   end
endmodule

`default_nettype wire
